// >>> rtl/imc_master_control.v
// Master control register, interrupt gating, stretch, loopback and back-off for a two-wire bus master
`timescale 1ns/1ps
`include "imc_defines.vh"

module imc_master_control (
  input  wire                   clk_i,
  input  wire                   reset_n_i,
  // Register port
  input  wire [`IMC_ADDR_W-1:0] addr_i,
  input  wire [15:0]            wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [15:0]            rdata_o,
  // Events from the master engine, one-cycle pulses on clk_i
  input  wire                   nack_i,
  input  wire                   arb_lost_i,
  input  wire                   tx_done_i,
  input  wire                   rx_done_i,
  // Engine line drive requests, high pulls the line low; then start and slave mode requests
  input  wire                   eng_scl_low_i,
  input  wire                   eng_sda_low_i,
  input  wire                   start_req_i,
  input  wire                   slave_req_i,
  // Open-drain pins
  input  wire                   scl_i,
  output reg                    scl_o,
  output reg                    scl_oe_o,
  input  wire                   sda_i,
  output reg                    sda_o,
  output reg                    sda_oe_o,
  // Line view and grants toward the engine; interrupt toward the processor
  output reg                    scl_in_o,
  output reg                    sda_in_o,
  output reg                    master_en_o,
  output reg                    slave_en_o,
  output reg                    start_ok_o,
  output reg                    irq_o
);

  // ==========================================
  // Reset synchroniser
  reg        rst_m_q;
  reg        rst_n_q;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // ==========================================
  // Address decode
  function sel;
    input [`IMC_ADDR_W-1:0] a;
    input [`IMC_ADDR_W-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  wire wr_ctrl = wr_i & sel(addr_i, `IMC_OFS_CTRL);
  wire wr_stat = wr_i & sel(addr_i, `IMC_OFS_STAT);
  wire wr_mask = wr_i & sel(addr_i, `IMC_OFS_MASK);

  // ==========================================
  // Pin synchronisers; first stage is read only by the second
  reg  [1:0] pin_m_q;
  reg  [1:0] pin_s_q;
  reg  [1:0] line_q;

  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_m_q <= 2'h3;
      pin_s_q <= 2'h3;
    end else begin
      pin_m_q <= {sda_i, scl_i};
      pin_s_q <= pin_m_q;
    end
  end

  // ==========================================
  // Registers
  reg  [15:0] ctrl_q;
  reg  [15:0] stat_q;
  reg  [15:0] mask_q;
  reg         busy_q;
  reg         hold_q;

  wire lb      = ctrl_q[`IMC_B_ILB];
  wire men     = ctrl_q[`IMC_B_MEN];
  wire scl_drv = eng_scl_low_i | hold_q;

  // In loopback the driven levels replace the pins, so the outside bus sees nothing
  wire scl_v = lb ? ~scl_drv : pin_s_q[0];
  wire sda_v = lb ? ~eng_sda_low_i : pin_s_q[1];

  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `IMC_CTRL_RST;
      mask_q <= `IMC_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_i & `IMC_CTRL_WMASK;
      end
      if (wr_mask) begin
        mask_q <= wdata_i & `IMC_IRQ_BITS;
      end
    end
  end

  // ==========================================
  // Start and stop detection on the line view
  // Edge of one line bit between the registered view and the current view
  function edge_of;
    input prev;
    input cur;
    input rising;
    begin
      edge_of = rising ? (~prev & cur) : (prev & ~cur);
    end
  endfunction

  // Both views are already synchronised, so a glitch caught by a clock edge is seen as a full cycle
  wire scl_fall = edge_of(line_q[0], scl_v, 1'b0);
  wire start_d  = line_q[0] & scl_v & edge_of(line_q[1], sda_v, 1'b0);
  wire stop_d   = line_q[0] & scl_v & edge_of(line_q[1], sda_v, 1'b1);

  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      line_q <= 2'h3;
      busy_q <= 1'b0;
    end else begin
      line_q <= {sda_v, scl_v};
      if (start_d) begin
        busy_q <= 1'b1;
      end else if (stop_d) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Clock stretch
  // A high line waits for its own falling edge so a running high phase is not cut short
  wire hold_d = ctrl_q[`IMC_B_STR] & (hold_q | ~line_q[0] | scl_fall);

  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ==========================================
  // Sticky status; a new event wins over a write-one clear
  wire [15:0] ev;
  assign ev[`IMC_B_XCIE] = stop_d;
  assign ev[`IMC_B_NAIE] = nack_i;
  assign ev[`IMC_B_ALIE] = arb_lost_i;
  assign ev[`IMC_B_TXIE] = tx_done_i;
  assign ev[`IMC_B_RXIE] = rx_done_i;
  assign ev[3:0]   = 4'h0;
  assign ev[15:9]  = 7'h00;

  wire [15:0] stat_d;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_stat
      if (gi >= `IMC_IRQ_LO && gi <= `IMC_IRQ_HI) begin : g_bit
        // Enables do not reach this flag
        assign stat_d[gi] = ev[gi] | (stat_q[gi] & ~(wr_stat & wdata_i[gi]));
      end else begin : g_zero
        assign stat_d[gi] = 1'b0;
      end
    end
  endgenerate

  // One process owns the whole word, so each bit has a single driver
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_q <= `IMC_STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // ==========================================
  // Outputs
  wire [15:0] irq_src = stat_q & ctrl_q & mask_q & `IMC_IRQ_BITS;
  wire [15:0] bus_rd  = {11'h000, slave_en_o, line_q[1], line_q[0], hold_q, busy_q};

  // Unmapped offsets read zero, so software probing the map sees no stale word
  function [15:0] rd_word;
    input [`IMC_ADDR_W-1:0] a;
    input [15:0]            c;
    input [15:0]            s;
    input [15:0]            m;
    input [15:0]            b;
    begin
      case (a)
        `IMC_OFS_CTRL: rd_word = c;
        `IMC_OFS_STAT: rd_word = s;
        `IMC_OFS_MASK: rd_word = m;
        `IMC_OFS_BUS:  rd_word = b;
        default:       rd_word = 16'h0000;
      endcase
    end
  endfunction

  // ==========================================
  // Pin drive; open drain, so the data outputs stay low and only the enables move
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= ~lb & scl_drv & men;
      sda_oe_o <= ~lb & eng_sda_low_i & men;
    end
  end

  // ==========================================
  // Line view toward the engine; idles high like a released bus
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_in_o <= 1'b1;
      sda_in_o <= 1'b1;
    end else begin
      scl_in_o <= scl_v;
      sda_in_o <= sda_v;
    end
  end

  // ==========================================
  // Mode grants
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      master_en_o <= 1'b0;
      slave_en_o  <= 1'b0;
      start_ok_o  <= 1'b0;
    end else begin
      master_en_o <= men;
      // Master wins when both are asked for, so the slave side never sees a half-set mode
      slave_en_o  <= slave_req_i & ~men;
      // Back-off only matters while the bus is busy, whoever sent the start that set busy_q
      start_ok_o  <= men & start_req_i & (~busy_q | ctrl_q[`IMC_B_BOD]);
    end
  end

  // ==========================================
  // Interrupt; a level, so a missed edge at the processor cannot lose an event
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |irq_src;
    end
  end

  // ==========================================
  // Read data stand for one cycle only, then fall back to zero
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? rd_word(addr_i, ctrl_q, stat_q, mask_q, bus_rd) : 16'h0000;
    end
  end

endmodule

// >>> rtl/imc_defines.vh
// Register map, field positions and reset values of the master control block
`ifndef IMC_DEFINES_VH
`define IMC_DEFINES_VH

// ==========================================
// Register offsets
`define IMC_ADDR_W      4
`define IMC_OFS_CTRL    4'h0
`define IMC_OFS_STAT    4'h4
`define IMC_OFS_MASK    4'h8
`define IMC_OFS_BUS     4'hc

// ==========================================
// Control register fields
`define IMC_B_MEN       0
`define IMC_B_BOD       1
`define IMC_B_ILB       2
`define IMC_B_STR       3
`define IMC_B_RXIE      4
`define IMC_B_TXIE      5
`define IMC_B_ALIE      6
`define IMC_B_NAIE      7
`define IMC_B_XCIE      8
`define IMC_CTRL_RST    16'h0000
`define IMC_CTRL_WMASK  16'h01ff

// ==========================================
// Status and mask share the enable layout
`define IMC_IRQ_LO      4
`define IMC_IRQ_HI      8
`define IMC_STAT_RST    16'h0000
`define IMC_MASK_RST    16'h01f0
`define IMC_IRQ_BITS    16'h01f0

// ==========================================
// Bus state register fields
`define IMC_S_BUSY      0
`define IMC_S_HOLD      1
`define IMC_S_SCL       2
`define IMC_S_SDA       3
`define IMC_S_SLV       4

`endif

// >>> test/imc_props.sv
// Port checker for the master control block
`timescale 1ns/1ps
module imc_props (
  input wire        clk_i, reset_n_i, wr_i, rd_i, nack_i, arb_lost_i, tx_done_i, rx_done_i, start_req_i,
  input wire [3:0]  addr_i,
  input wire [15:0] wdata_i, rdata_o,
  input wire        scl_oe_o, sda_oe_o, scl_in_o, sda_in_o, master_en_o, slave_en_o, start_ok_o, irq_o
);
  reg [15:0] ctl_q;
  reg [15:0] msk_q;
  // ==========
  // Shadow copies, so the enables are known at the ports
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_q <= 16'h0000;
      msk_q <= 16'h01f0;
    end else if (wr_i) begin
      if (addr_i == 4'h0) ctl_q <= wdata_i;
      if (addr_i == 4'h8) msk_q <= wdata_i;
    end
  end
  wire [4:0] en = ctl_q[8:4] & msk_q[8:4];
  wire       st = ctl_q[3] && ctl_q[0] && !ctl_q[2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========
  // Assertions
  ctl_read_a: assert property (rd_i && addr_i == 4'h0 |=> rdata_o == (ctl_q & 16'h01ff))
    else $error("control read wrong");
  stop_irq_a: assert property ($rose(sda_in_o) && scl_in_o && en[4] |-> ##[1:6] irq_o)
    else $error("stop gave no interrupt");
  ev_irq_a: assert property (|({nack_i, arb_lost_i, tx_done_i, rx_done_i} & en[3:0]) |-> ##2 irq_o)
    else $error("event gave no interrupt");
  irq_off_a: assert property (en == 5'h00 |=> !irq_o)
    else $error("interrupt while all disabled");
  men_a: assert property (master_en_o == $past(ctl_q[0]))
    else $error("master enable wrong");
  excl_a: assert property (!(master_en_o && slave_en_o))
    else $error("master and slave both on");
  start_a: assert property (start_ok_o |-> $past(ctl_q[0] && start_req_i))
    else $error("start granted without cause");
  loop_a: assert property (ctl_q[2] |=> !scl_oe_o && !sda_oe_o)
    else $error("pins driven in loopback");
  str_hold_a: assert property (st && scl_oe_o |=> scl_oe_o)
    else $error("stretch hold dropped");
  str_fall_a: assert property (st && $fell(scl_in_o) |-> ##[0:4] scl_oe_o)
    else $error("no hold after falling edge");
endmodule

// >>> test/imc_bus_model.sv
// Far side of the two-wire bus: pull-ups and a frame driver
`timescale 1ns/1ps
module imc_bus_model (
  input  wire scl_oe_i,
  input  wire sda_oe_i,
  output wire scl_o,
  output wire sda_o
);
  reg scl_low = 0;
  reg sda_low = 0;
  // Pull-ups: a released line reads high; the clock moves from the frame tasks and from direct writes to scl_low
  assign scl_o = !(scl_low || scl_oe_i);
  assign sda_o = !(sda_low || sda_oe_i);
  task start;
    sda_low = 1;
    #62.5 scl_low = 1;
  endtask
  task pulses(input integer n);
    repeat (n) begin
      #62.5 scl_low = 0;
      #62.5 scl_low = 1;
    end
  endtask
  task stop;
    #62.5 scl_low = 0;
    #62.5 sda_low = 0;
  endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the master control block
`timescale 1ns/1ps
module tb;
  reg        clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, start_req_i = 0, slave_req_i = 0, rd_q = 0;
  reg        eng_scl_low_i = 0, eng_sda_low_i = 0;
  reg [3:0]  addr_i = 4'h0, ev = 4'h0;
  reg [15:0] wdata_i = 16'h0000, w;
  reg [15:0] q[$];
  wire       nack_i = ev[3], arb_lost_i = ev[2], tx_done_i = ev[1], rx_done_i = ev[0];
  wire [15:0] rdata_o;
  wire       scl_i, sda_i, scl_o, sda_o, scl_oe_o, sda_oe_o, scl_in_o, sda_in_o;
  wire       master_en_o, slave_en_o, start_ok_o, irq_o;
  integer    num_errors = 0, num_checks = 0, seed = 32'hddad, i;
  imc_master_control uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .nack_i(nack_i), .arb_lost_i(arb_lost_i), .tx_done_i(tx_done_i),
    .rx_done_i(rx_done_i), .eng_scl_low_i(eng_scl_low_i), .eng_sda_low_i(eng_sda_low_i),
    .start_req_i(start_req_i), .slave_req_i(slave_req_i), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_in_o(scl_in_o),
    .sda_in_o(sda_in_o), .master_en_o(master_en_o), .slave_en_o(slave_en_o), .start_ok_o(start_ok_o),
    .irq_o(irq_o));
  imc_bus_model bm (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
  initial forever #2.5 clk_i = ~clk_i;
  // ==========
  // Tasks
  task cmp(input [15:0] e, input [15:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task chk(input e, input g);
    cmp({15'h0, e}, {15'h0, g});
  endtask
  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    q.push_back(e);
    @(posedge clk_i);
    rd_i <= 0;
  endtask
  task pulse(input [3:0] e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_q) cmp(q.pop_front(), rdata_o);
    rd_q <= rd_i;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    test_done;
  end
  // ==========
  // Scenarios
  initial begin
    cyc(16);
    reset_n_i <= 1;
    cyc(3);
    rd(4'h0, 16'h0000);
    rd(4'h8, 16'h01f0);
    rd(4'h2, 16'h0000);
    w = $random(seed);
    wr(4'h0, w & 16'h00f2);
    rd(4'h0, w & 16'h00f2);
    wr(4'h0, 16'h00f0);
    for (i = 0; i < 4; i = i + 1) begin
      pulse(4'h1 << i);
      cyc(1);
      chk(1, irq_o);
      rd(4'h4, 16'h0010 << i);
      wr(4'h4, 16'h0010 << i);
      cyc(2);
      chk(0, irq_o);
    end
    wr(4'h8, 16'h0000);
    pulse(4'h8);
    cyc(3);
    chk(0, irq_o);
    wr(4'h0, 16'h0000);
    rd(4'h4, 16'h0080);
    wr(4'h8, 16'h01f0);
    wr(4'h0, 16'h0080);
    cyc(2);
    chk(1, irq_o);
    wr(4'h4, 16'h0080);
    slave_req_i <= 1;
    start_req_i <= 1;
    wr(4'h0, 16'h0101);
    cyc(3);
    chk(1, master_en_o);
    chk(0, slave_en_o);
    bm.start();
    cyc(8);
    chk(0, start_ok_o);
    rd(4'hc, 16'h0001);
    wr(4'h0, 16'h0103);
    cyc(3);
    chk(1, start_ok_o);
    bm.pulses(2);
    bm.stop();
    cyc(8);
    chk(1, irq_o);
    wr(4'h0, 16'h0001);
    cyc(3);
    chk(1, start_ok_o);
    wr(4'h0, 16'h0000);
    cyc(3);
    chk(1, slave_en_o);
    rd(4'hc, 16'h001c);
    // Stretch set while the line is low, then while it is high
    bm.scl_low = 1;
    cyc(4);
    wr(4'h0, 16'h0009);
    cyc(4);
    bm.scl_low = 0;
    cyc(6);
    chk(0, scl_i);
    wr(4'h0, 16'h0001);
    cyc(6);
    chk(1, scl_i);
    wr(4'h0, 16'h0009);
    cyc(6);
    chk(0, scl_oe_o);
    bm.pulses(1);
    cyc(6);
    bm.scl_low = 0;
    cyc(6);
    chk(0, scl_i);
    chk(1, scl_oe_o);
    chk(0, scl_o | sda_o);
    wr(4'h0, 16'h0005);
    for (i = 1; i < 3; i = i + 1) begin
      @(posedge clk_i) {eng_scl_low_i, eng_sda_low_i} <= i[1:0];
      cyc(4);
      cmp({14'h0, ~i[1:0]}, {12'h0, scl_oe_o, sda_oe_o, scl_in_o, sda_in_o});
    end
    wr(4'h0, 16'h0001);
    cyc(3);
    chk(1, scl_oe_o);
    @(posedge clk_i) {eng_scl_low_i, eng_sda_low_i} <= 2'b01;
    cyc(3);
    chk(1, sda_oe_o);
    test_done;
  end
endmodule
bind imc_master_control imc_props chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr_i), .rd_i(rd_i), .nack_i(nack_i), .arb_lost_i(arb_lost_i),
  .tx_done_i(tx_done_i), .rx_done_i(rx_done_i), .start_req_i(start_req_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .scl_in_o(scl_in_o),
  .sda_in_o(sda_in_o), .master_en_o(master_en_o), .slave_en_o(slave_en_o), .start_ok_o(start_ok_o),
  .irq_o(irq_o));
